// file: common/tbsp_map.svh
// Purpose: Register offsets, field positions, opcodes and reset values of the TAP port.
// Assumes: Included by bare name after the package.
// Notes:   Definitions only.
`ifndef TBSP_MAP_SVH
`define TBSP_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TBSP_OFF_STATUS      8'h00
`define TBSP_OFF_CTRL        8'h04
`define TBSP_OFF_DATA        8'h08
`define TBSP_OFF_IDVIEW      8'h0C

// ****************************************
// Field positions and reset values
// ****************************************
`define TBSP_CTRL_FITTED_BIT 0
`define TBSP_CTRL_LOG_BIT    1
`define TBSP_CTRL_RESET      2'h1
`define TBSP_ST_OVF_BIT      18
`define TBSP_CHAIN_RESET     5'h00
`define TBSP_BND_CHAIN       5'h03

// ****************************************
// Instruction opcodes
// ****************************************
`define TBSP_IR_EXTEST       4'h0
`define TBSP_IR_SCAN_N       4'h2
`define TBSP_IR_SAMPLE       4'h3
`define TBSP_IR_CLAMP        4'h5
`define TBSP_IR_CLAMP_TRI    4'h9
`define TBSP_IR_INTEST       4'hC
`define TBSP_IR_IDCODE       4'hE
`define TBSP_IR_CAPTURE      4'h1

// ****************************************
// Bus responses
// ****************************************
`define TBSP_RESP_OKAY       2'h0
`define TBSP_RESP_SLVERR     2'h2

`endif

// file: common/tbsp_pkg.sv
// Purpose: Types shared by the TAP port design.
// Assumes: Constants live in tbsp_map.svh.
// Notes:   Enum order fixes the four-bit state code.
`default_nettype none
package tbsp_pkg;

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } tbsp_tap_t;

   // ****************************************
   // Sampled test pins
   // ****************************************
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
      logic ext_so;
   } tbsp_pins_t;

endpackage
`default_nettype wire

// file: core/tbsp_top.sv
// Purpose: Test access port with boundary-scan support strobes and an AXI4-Lite view.
// Assumes: All test pins are asynchronous to aclk; test clock well below aclk/4.
// Notes:   Scan log words pass through a FIFO that software drains.
//
// Summary of operation
// - Cell enable updates in UPDATE-IR on chain 3 from boundary-type opcodes.
// - External capture strobe pulses in phase two of CAPTURE-DR under EXTEST, chain 3.
// - Internal capture strobe pulses in phase two of CAPTURE-DR under INTEST, chain 3.
// - Opcode view shows instruction, changing at falling test clock in UPDATE-IR.
// - Update strobe pulses in phase two of UPDATE-DR with chain 3 selected.
// - Boundary reset strobe high in Test-Logic-Reset or while test reset is low.
// - Chain number view changes at falling test clock in UPDATE-DR.
// - Serial data to external chain is stable around the falling test clock.
// - Master shift clock follows phase one in SHIFT-DR on chain 3, else low.
// - Slave shift clock follows phase two in SHIFT-DR on chain 3, else low.
// - Identification pins, bit 0 set, are returned as the ID data register; the code returns the pins as they are, bit 0 not forced.
// - State view shows controller state, changing from the rising test clock.
// - Two non-overlapping phases: one while clock high, two while low.
// - Output drive flag high exactly while serial data drives the output.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tbsp_map.svh"

// ****************************************
// Scan log FIFO
// ****************************************
module tbsp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               cnt;
   } tbsp_fifo_st_t;

   tbsp_fifo_st_t r, n;
   logic          push;
   logic          pop;

   assign in_ready  = (r.cnt != CW'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rp];

   always_comb begin
      n    = r;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp        = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      // Depth is a power of two so pointers wrap by themselves
      n.cnt = r.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule

// ****************************************
// Top level
// ****************************************
module tbsp_top import tbsp_pkg::*; #(
   parameter int ADDR_W     = 8,
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Test port pins
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   input  wire logic              test_reset_n,
   output logic                   test_data_out,
   output logic                   serial_output_drive_flag,
   input  wire logic [31:0]       identification_value_input,
   // External boundary chain
   input  wire logic              serial_from_external_chain,
   output logic                   serial_to_external_chain,
   output logic                   master_shift_clock,
   output logic                   slave_shift_clock,
   output logic                   external_test_capture_strobe,
   output logic                   internal_test_capture_strobe,
   output logic                   boundary_update_strobe,
   output logic                   boundary_reset_strobe,
   output logic                   boundary_cell_enable,
   // Phases and views
   output logic                   test_clock_phase_one,
   output logic                   test_clock_phase_two,
   output logic [3:0]             controller_state_view,
   output logic [3:0]             loaded_opcode_view,
   output logic [4:0]             selected_chain_number
);
   typedef struct packed {
      tbsp_pins_t        pin_m;
      tbsp_pins_t        pin_s;
      logic              tck_d;
      logic [31:0]       id_m;
      logic [31:0]       id_s;
      tbsp_tap_t         tap;
      logic [3:0]        ir;
      logic [3:0]        ir_sh;
      logic [31:0]       dr;
      logic [31:0]       log_w;
      logic [4:0]        chain;
      logic              tdo;
      logic              tdo_en;
      logic              to_chain;
      logic              ph1;
      logic              ph2;
      logic              msh;
      logic              ssh;
      logic              ecap;
      logic              icap;
      logic              upd;
      logic              brst;
      logic              cell_en;
      logic [1:0]        ctrl;
      logic              ovf;
      logic              push_v;
      logic [31:0]       push_d;
      logic              aw_h;
      logic [ADDR_W-1:0] aw_a;
      logic              w_h;
      logic [31:0]       w_d;
      logic [3:0]        w_s;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } tbsp_top_st_t;

   tbsp_top_st_t r, n;
   logic         rise;
   logic         fall;
   logic         trst_low;
   logic         ext_in;
   logic         bnd_sel;
   logic         fifo_in_ready;
   logic         fifo_out_valid;
   logic         fifo_pop;
   logic [31:0]  fifo_out_data;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic tbsp_tap_t tap_next(input tbsp_tap_t s, input logic m);
      unique case (s)
         ST_TLR:      tap_next = m ? ST_TLR : ST_RTI;
         ST_RTI:      tap_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR:   tap_next = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR:   tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
         ST_UPD_DR:   tap_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR:   tap_next = m ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR:   tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
         ST_UPD_IR:   tap_next = m ? ST_SEL_DR : ST_RTI;
      endcase
   endfunction

   function automatic logic is_bnd_op(input logic [3:0] op);
      is_bnd_op = (op == `TBSP_IR_INTEST) || (op == `TBSP_IR_EXTEST) ||
                  (op == `TBSP_IR_CLAMP)  || (op == `TBSP_IR_CLAMP_TRI);
   endfunction

   tbsp_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (r.push_v),
      .in_ready  (fifo_in_ready),
      .in_data   (r.push_d),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      n        = r;
      n.pin_m  = {tck, tms, tdi, test_reset_n, serial_from_external_chain};
      n.pin_s  = r.pin_m;
      n.tck_d  = r.pin_s.tck;
      n.id_m   = identification_value_input;
      n.id_s   = r.id_m;
      rise     = r.pin_s.tck && !r.tck_d;
      fall     = !r.pin_s.tck && r.tck_d;
      trst_low = !r.pin_s.trst_n;
      // Absent chain reads low even if the pin floats
      ext_in   = r.pin_s.ext_so && r.ctrl[`TBSP_CTRL_FITTED_BIT];
      bnd_sel  = (r.chain == `TBSP_BND_CHAIN);
      fifo_pop = 1'b0;

      // Write channel: address and data taken in either order
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s_axi_awvalid && r.awready) begin
         n.aw_h = 1'b1;
         n.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_h = 1'b1;
         n.w_d = s_axi_wdata;
         n.w_s = s_axi_wstrb;
      end
      if (n.aw_h && n.w_h && !r.bvalid) begin
         n.aw_h   = 1'b0;
         n.w_h    = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `TBSP_RESP_OKAY;
         case (n.aw_a)
            `TBSP_OFF_CTRL: begin
               if (n.w_s[0]) begin
                  n.ctrl = n.w_d[1:0];
               end
            end
            `TBSP_OFF_STATUS: begin
               if (n.w_s[2] && n.w_d[`TBSP_ST_OVF_BIT]) begin
                  n.ovf = 1'b0;
               end
            end
            `TBSP_OFF_DATA, `TBSP_OFF_IDVIEW: begin
            end
            default: n.bresp = `TBSP_RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_h && !n.bvalid;
      n.wready  = !n.w_h && !n.bvalid;

      // Read channel: one read in flight, data a cycle after address
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = `TBSP_RESP_OKAY;
         case (s_axi_araddr)
            `TBSP_OFF_STATUS: n.rdata = {12'h000, r.cell_en, r.ovf, !fifo_in_ready, !fifo_out_valid,
                                         3'h0, r.chain, r.ir, r.tap};
            `TBSP_OFF_CTRL:   n.rdata = {30'h0, r.ctrl};
            `TBSP_OFF_DATA: begin
               n.rdata  = fifo_out_valid ? fifo_out_data : 32'h0000_0000;
               fifo_pop = fifo_out_valid;
            end
            `TBSP_OFF_IDVIEW: n.rdata = r.id_s;
            default: begin
               n.rdata = 32'h0000_0000;
               n.rresp = `TBSP_RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;

      // Log word leaves once the FIFO takes it
      if (r.push_v && fifo_in_ready) begin
         n.push_v = 1'b0;
      end

      // Controller and scan registers
      if (trst_low) begin
         n.tap     = ST_TLR;
         n.ir      = `TBSP_IR_IDCODE;
         n.chain   = `TBSP_CHAIN_RESET;
         n.cell_en = 1'b0;
         n.tdo_en  = 1'b0;
      end else begin
         if (r.tap == ST_TLR) begin
            n.ir = `TBSP_IR_IDCODE;
         end
         if (rise) begin
            unique case (r.tap)
               ST_CAP_IR:   n.ir_sh = `TBSP_IR_CAPTURE;
               ST_SHIFT_IR: n.ir_sh = {r.pin_s.tdi, r.ir_sh[3:1]};
               ST_CAP_DR: begin
                  case (r.ir)
                     `TBSP_IR_IDCODE: n.dr = r.id_s;
                     `TBSP_IR_SCAN_N: n.dr = {27'h0, r.chain};
                     `TBSP_IR_EXTEST, `TBSP_IR_INTEST, `TBSP_IR_SAMPLE:
                        n.dr = {31'h0, bnd_sel && ext_in};
                     default: n.dr = 32'h0000_0000;
                  endcase
               end
               ST_SHIFT_DR: begin
                  n.log_w = {r.pin_s.tdi, r.log_w[31:1]};
                  n.to_chain = r.pin_s.tdi;
                  case (r.ir)
                     `TBSP_IR_IDCODE: n.dr = {r.pin_s.tdi, r.dr[31:1]};
                     `TBSP_IR_SCAN_N: n.dr = {27'h0, r.pin_s.tdi, r.dr[4:1]};
                     `TBSP_IR_EXTEST, `TBSP_IR_INTEST, `TBSP_IR_SAMPLE:
                        n.dr = {31'h0, bnd_sel ? ext_in : r.pin_s.tdi};
                     default: n.dr = {31'h0, r.pin_s.tdi};
                  endcase
               end
               default: begin
               end
            endcase
            n.tap = tap_next(r.tap, r.pin_s.tms);
            // A new log word is lost, and overflow set, if the last one still waits when the next scan ends
            if (n.tap == ST_UPD_DR && r.ctrl[`TBSP_CTRL_LOG_BIT]) begin
               if (r.push_v && !fifo_in_ready) begin
                  n.ovf = 1'b1;
               end else begin
                  n.push_v = 1'b1;
                  n.push_d = r.log_w;
               end
            end
         end
         if (fall) begin
            if (r.tap == ST_UPD_IR) begin
               n.ir = r.ir_sh;
               if (bnd_sel) begin
                  n.cell_en = is_bnd_op(r.ir_sh);
               end
            end
            if (r.tap == ST_UPD_DR && r.ir == `TBSP_IR_SCAN_N) begin
               n.chain = r.dr[4:0];
            end
            n.tdo_en = (r.tap == ST_SHIFT_IR) || (r.tap == ST_SHIFT_DR);
            if (r.tap == ST_SHIFT_IR) begin
               n.tdo = r.ir_sh[0];
            end else if (r.tap == ST_SHIFT_DR) begin
               n.tdo = r.dr[0];
            end
         end
      end

      // Phase one lags the rising edge, phase two the falling edge
      n.ph1  = r.pin_s.tck && r.tck_d;
      n.ph2  = !r.pin_s.tck && !r.tck_d;
      n.msh  = n.ph1 && r.tap == ST_SHIFT_DR && bnd_sel;
      n.ssh  = n.ph2 && r.tap == ST_SHIFT_DR && bnd_sel;
      n.ecap = n.ph2 && r.tap == ST_CAP_DR && r.ir == `TBSP_IR_EXTEST && bnd_sel;
      n.icap = n.ph2 && r.tap == ST_CAP_DR && r.ir == `TBSP_IR_INTEST && bnd_sel;
      n.upd  = n.ph2 && r.tap == ST_UPD_DR && bnd_sel;
      n.brst = trst_low || r.tap == ST_TLR;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r      <= '0;
         r.ir   <= `TBSP_IR_IDCODE;
         r.ctrl <= `TBSP_CTRL_RESET;
         r.brst <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready                = r.awready;
   assign s_axi_wready                 = r.wready;
   assign s_axi_bvalid                 = r.bvalid;
   assign s_axi_bresp                  = r.bresp;
   assign s_axi_arready                = r.arready;
   assign s_axi_rvalid                 = r.rvalid;
   assign s_axi_rresp                  = r.rresp;
   assign s_axi_rdata                  = r.rdata;
   assign test_data_out                = r.tdo;
   assign serial_output_drive_flag     = r.tdo_en;
   assign serial_to_external_chain     = r.to_chain;
   assign master_shift_clock           = r.msh;
   assign slave_shift_clock            = r.ssh;
   assign external_test_capture_strobe = r.ecap;
   assign internal_test_capture_strobe = r.icap;
   assign boundary_update_strobe       = r.upd;
   assign boundary_reset_strobe        = r.brst;
   assign boundary_cell_enable         = r.cell_en;
   assign test_clock_phase_one         = r.ph1;
   assign test_clock_phase_two         = r.ph2;
   assign controller_state_view        = r.tap;
   assign loaded_opcode_view           = r.ir;
   assign selected_chain_number        = r.chain;

   // ****************************************
   // Checks
   // ****************************************
   a_cell_enable_upd: assert property (
      $changed(r.cell_en) |-> $past(trst_low) || $past(fall && r.tap == ST_UPD_IR && bnd_sel))
      else $error("cell enable changed outside UPDATE-IR on chain 3");
   a_ext_capture: assert property (
      r.ecap |-> r.ph2 && $past(r.tap == ST_CAP_DR && r.ir == `TBSP_IR_EXTEST && bnd_sel))
      else $error("external capture strobe without EXTEST capture");
   a_int_capture: assert property (
      r.icap |-> r.ph2 && $past(r.tap == ST_CAP_DR && r.ir == `TBSP_IR_INTEST && bnd_sel))
      else $error("internal capture strobe without INTEST capture");
   a_opcode_view_edge: assert property (
      $changed(r.ir) |-> $past(trst_low || r.tap == ST_TLR) || $past(fall && r.tap == ST_UPD_IR))
      else $error("opcode view changed outside UPDATE-IR falling edge");
   a_update_pulse: assert property (
      r.upd |-> r.ph2 && $past(r.tap == ST_UPD_DR && bnd_sel))
      else $error("update strobe outside UPDATE-DR on chain 3");
   a_reset_strobe: assert property (
      (trst_low || r.tap == ST_TLR) |=> r.brst)
      else $error("boundary reset strobe missing");
   a_chain_view_edge: assert property (
      $changed(r.chain) |-> $past(trst_low) || $past(fall && r.tap == ST_UPD_DR))
      else $error("chain number changed outside UPDATE-DR falling edge");
   a_chain_data_timing: assert property (
      $changed(r.to_chain) |-> $past(rise))
      else $error("serial data to chain changed off the rising edge");
   a_master_shift: assert property (
      r.msh |-> !r.ssh && $past(r.tap == ST_SHIFT_DR && bnd_sel && r.pin_s.tck))
      else $error("master shift clock outside SHIFT-DR phase one");
   a_slave_shift: assert property (
      r.ssh |-> $past(r.tap == ST_SHIFT_DR && bnd_sel && !r.pin_s.tck))
      else $error("slave shift clock outside SHIFT-DR phase two");
   a_id_capture: assert property (
      (rise && !trst_low && r.tap == ST_CAP_DR && r.ir == `TBSP_IR_IDCODE) |=> r.dr == $past(r.id_s))
      else $error("ID register not captured from pins");
   a_state_view_edge: assert property (
      $changed(r.tap) |-> $past(rise || trst_low))
      else $error("state view changed off the rising edge");
   a_phase_gap: assert property (
      r.ph1 |-> !r.ph2 && $past(r.pin_s.tck))
      else $error("clock phases overlap");
   a_drive_flag: assert property (
      $changed(r.tdo_en) |-> $past(fall || trst_low))
      else $error("drive flag changed off the falling edge");
endmodule

`default_nettype wire

// file: tb/tbsp_jtag_model.sv
// Purpose: Debugger on the test pins, one-cell external chain.
// Assumes: Each scan starts in idle or reset.
// Notes:   Test clock 64 ns, idle low between scans.
`timescale 1ns/10ps
`default_nettype none
module tbsp_jtag_model (
   // Test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   // External chain
   input  wire logic msh,
   input  wire logic sin,
   output logic      sout
);
   initial {tck, tms, tdi, sout} = 4'h4;
   task step(input logic m, input logic t, output logic o);
      {tms, tdi} <= {m, t};
      #32 tck <= 1'h1;
      #31 o = tdo;  // Late sample, clear of output update
      #1 tck <= 1'h0;
   endtask
   task scan(input logic ir, input logic [31:0] v, input int n, output logic [31:0] q);
      logic o;
      step(1'h0, 1'h0, o);
      step(1'h1, 1'h0, o);
      if (ir) step(1'h1, 1'h0, o);
      repeat (2) step(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, v[i], o);
         q = {o, q[31:1]};
      end
      step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      #160 $display("scan of %0d bits done", n);
   endtask
   always @(posedge msh) sout <= sin;
endmodule
`default_nettype wire

// file: tb/tb_tbsp_top.sv
// Purpose: Self-checking bench for the TAP port.
// Assumes: The debugger model owns the test pins.
// Notes:   Sticky flags catch three-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module tb_tbsp_top;
   localparam logic [31:0] id_word = 32'h1A2B_3C4D;  // Arbitrary value, bit 0 set
   logic        aclk, aresetn, tck, tms, tdi, test_reset_n, test_data_out, serial_output_drive_flag;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, serial_from_external_chain;
   logic        serial_to_external_chain, master_shift_clock, slave_shift_clock, boundary_reset_strobe;
   logic        external_test_capture_strobe, internal_test_capture_strobe, boundary_update_strobe;
   logic        boundary_cell_enable, test_clock_phase_one, test_clock_phase_two;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  s_axi_wstrb, controller_state_view, loaded_opcode_view;
   logic [4:0]  selected_chain_number;
   logic [6:0]  seen;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, identification_value_input, d, q;
   int          fail_count, samples_checked;
   tbsp_top u_tbsp_top (.*);
   tbsp_jtag_model u_tbsp_jtag_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(test_data_out),
      .msh(master_shift_clock), .sin(serial_to_external_chain), .sout(serial_from_external_chain));
   // Cleared on leaving idle, so a check sees one scan; bit 6 is phase overlap
   always @(posedge aclk) seen <= (controller_state_view == 4'h2) ? 7'h00 : seen | {test_clock_phase_one &
      test_clock_phase_two, serial_output_drive_flag, external_test_capture_strobe, internal_test_capture_strobe,
      boundary_update_strobe, master_shift_clock, slave_shift_clock};
   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task give_verdict;
      $display("%0d checks, %0d mismatches", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      for (int i = 0; i < 99; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_bvalid | s_axi_rvalid) begin
            {s_axi_bready, s_axi_rready} <= 2'h0;
            {d, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            return;
         end
      end
      fail_count++;
      give_verdict();
   endtask
   task sc(input logic ir, input logic [31:0] v, input int n);
      u_tbsp_jtag_model.scan(ir, v, n, q);
   endtask
   initial begin
      {aresetn, test_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
      identification_value_input = id_word;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (6) @(posedge aclk);
      chk(boundary_reset_strobe, 1'h1);
      test_reset_n <= 1'h1;
      xfer(1'h0, 8'h04, 32'h0);
      chk(d, 32'h1);
      xfer(1'h1, 8'h04, 32'h3);
      chk(r, 2'h0);
      xfer(1'h0, 8'h10, 32'h0);
      chk(r, 2'h2);
      xfer(1'h0, 8'h0C, 32'h0);
      chk(d, id_word);
      sc(1'h0, 32'h5A5A_0F0F, 32);
      chk(q, id_word);
      chk(controller_state_view, 4'h1);
      chk(boundary_reset_strobe, 1'h0);
      sc(1'h1, 32'h2, 4);
      chk(loaded_opcode_view, 4'h2);
      sc(1'h0, 32'h3, 5);
      chk(selected_chain_number, 5'h03);
      sc(1'h1, 32'h0, 4);
      chk(boundary_cell_enable, 1'h1);
      sc(1'h0, 32'h1, 1);
      chk(seen, 7'h37);
      chk(serial_to_external_chain, 1'h1);
      sc(1'h1, 32'hC, 4);
      sc(1'h0, 32'h1, 1);
      chk(seen, 7'h2F);
      xfer(1'h0, 8'h08, 32'h0);
      chk(d, 32'h5A5A_0F0F);
      xfer(1'h0, 8'h00, 32'h0);
      chk(d, 32'h0008_03C1);
      give_verdict();
   end
endmodule
`default_nettype wire
